// ==== ucr_defs.vh ====
`ifndef UCR_DEFS_VH
`define UCR_DEFS_VH

// Serial timing
`define UCR_CLK_HZ        250000000
`define UCR_BAUD          115200
`define UCR_BIT_CYC       (`UCR_CLK_HZ / `UCR_BAUD)
`define UCR_HALF_CYC      (`UCR_BIT_CYC / 2)
`define UCR_DATA_BITS     8
`define UCR_FRAME_BITS    10

// Buffer
`define UCR_FIFO_DEPTH    8
`define UCR_PTR_W         3
`define UCR_CNT_W         4

// Byte classes and command map
`define UCR_ADDR_FLAG_BIT 7
`define UCR_ADDR_LAST     8'h9_F
`define UCR_ADDR_MMO_MODE 8'h8_0
`define UCR_MMO_MODE_LAST 7'h0_2

// Output pin functions
`define UCR_MMO_LEVEL     2'h0
`define UCR_MMO_PWM       2'h1
`define UCR_MMO_SERIAL    2'h2
`define UCR_MMO_RESET     `UCR_MMO_LEVEL

`endif

// ==== ucr_receiver.v ====
`timescale 1ns/1ps
`include "ucr_defs.vh"

module ucr_receiver (
	input  wire       clk,
	input  wire       rst,
	input  wire       ce,
	input  wire       uart_rx,
	input  wire       detect_level,
	input  wire       pwm_level,
	input  wire       tx_valid,
	input  wire [7:0] tx_data,
	output wire       tx_ready,
	input  wire       err_clear,
	output reg        multimode_output_pin,
	output reg  [1:0] mmo_mode_reg,
	output reg        cmd_valid_reg,
	output reg  [7:0] cmd_addr_reg,
	output reg  [6:0] cmd_param_reg,
	output reg        err_noise_reg,
	output reg        err_frame_reg,
	output reg        err_overrun_reg,
	output reg        err_syntax_reg,
	output wire [3:0] fifo_level
);

	////////////////////////////////////////////////////////////////////////
	localparam [3:0] RX_IDLE  = 4'b0001;
	localparam [3:0] RX_START = 4'b0010;
	localparam [3:0] RX_DATA  = 4'b0100;
	localparam [3:0] RX_STOP  = 4'b1000;
	localparam [1:0] TX_IDLE  = 2'b01;
	localparam [1:0] TX_SHIFT = 2'b10;
	// Counts fit twelve bits at this clock; the slice makes the cut explicit
	localparam integer BIT_CYC_I  = `UCR_BIT_CYC;
	localparam integer HALF_CYC_I = `UCR_HALF_CYC;
	localparam [11:0]  BIT_CYC    = BIT_CYC_I[11:0];
	localparam [11:0]  HALF_CYC   = HALF_CYC_I[11:0];

	// Address decode used by the parser for the validity check; value checks use value_legal
	function addr_known;
		input [7:0] a;
		begin
			addr_known = a[`UCR_ADDR_FLAG_BIT] && (a <= `UCR_ADDR_LAST);
		end
	endfunction

	function value_legal;
		input [7:0] a;
		input [6:0] v;
		begin
			if (a == `UCR_ADDR_MMO_MODE)
				value_legal = (v <= `UCR_MMO_MODE_LAST);
			else
				value_legal = 1'b1;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Receive framing
	reg  [3:0]  rx_state_reg;
	reg  [11:0] rx_cnt_reg;
	reg  [2:0]  rx_bit_reg;
	reg  [7:0]  rx_shift_reg;
	reg         rx_prev_reg;
	reg         ev_noise;
	reg         ev_frame;
	reg         ev_byte;
	wire        rx_fall = rx_prev_reg & ~uart_rx;
	wire        rx_tick = (rx_cnt_reg == 12'h0_000);

	// No running-mode input gates this path: sleep never blocks reception
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_state_reg <= RX_IDLE;
			rx_cnt_reg   <= 12'h0_000;
			rx_bit_reg   <= 3'h0;
			rx_shift_reg <= 8'h0_0;
			rx_prev_reg  <= 1'b1;
			ev_noise     <= 1'b0;
			ev_frame     <= 1'b0;
			ev_byte      <= 1'b0;
		end else if (ce) begin
			rx_prev_reg <= uart_rx;
			ev_noise    <= 1'b0;
			ev_frame    <= 1'b0;
			ev_byte     <= 1'b0;
			if (!rx_tick)
				rx_cnt_reg <= rx_cnt_reg - 12'h0_001;
			case (rx_state_reg)
			RX_IDLE: begin
				// Only a falling edge starts a frame, so a dropped byte resyncs here
				if (rx_fall) begin
					rx_cnt_reg   <= HALF_CYC - 12'h0_001;
					rx_state_reg <= RX_START;
				end
			end
			RX_START: begin
				if (rx_tick) begin
					if (uart_rx) begin
						ev_noise     <= 1'b1;
						rx_state_reg <= RX_IDLE;
					end else begin
						rx_cnt_reg   <= BIT_CYC - 12'h0_001;
						rx_bit_reg   <= 3'h0;
						rx_state_reg <= RX_DATA;
					end
				end
			end
			RX_DATA: begin
				if (rx_tick) begin
					// Least significant bit arrives first
					rx_shift_reg <= {uart_rx, rx_shift_reg[7:1]};
					rx_cnt_reg   <= BIT_CYC - 12'h0_001;
					rx_bit_reg   <= rx_bit_reg + 3'h1;
					if (rx_bit_reg == 3'h7)
						rx_state_reg <= RX_STOP;
				end
			end
			RX_STOP: begin
				if (rx_tick) begin
					// Back to idle mid stop bit leaves half a bit to catch the next edge
					if (uart_rx)
						ev_byte <= 1'b1;
					else
						ev_frame <= 1'b1;
					rx_state_reg <= RX_IDLE;
				end
			end
			default: rx_state_reg <= RX_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Eight-entry buffer between framing and parser
	reg  [7:0] fifo_mem [0:`UCR_FIFO_DEPTH-1];
	reg  [2:0] wr_ptr_reg;
	reg  [2:0] rd_ptr_reg;
	reg  [3:0] count_reg;
	wire       fifo_full  = (count_reg == `UCR_FIFO_DEPTH);
	wire       fifo_empty = (count_reg == 4'h0);
	wire       push       = ev_byte & ~fifo_full;
	wire       ev_overrun = ev_byte & fifo_full;
	wire       pop        = ~fifo_empty;
	wire [7:0] head       = fifo_mem[rd_ptr_reg];

	assign fifo_level = count_reg;

	always @(posedge clk) begin
		if (ce && push)
			fifo_mem[wr_ptr_reg] <= rx_shift_reg;
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr_reg <= 3'h0;
			rd_ptr_reg <= 3'h0;
			count_reg  <= 4'h0;
		end else if (ce) begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 3'h1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 3'h1;
			case ({push, pop})
			2'b10:   count_reg <= count_reg + 4'h1;
			2'b01:   count_reg <= count_reg - 4'h1;
			default: count_reg <= count_reg;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Command parser
	// Line faults clear the pending address at once, even if older bytes still wait in the buffer
	reg        pend_valid_reg;
	reg  [7:0] pend_addr_reg;
	reg        ev_syntax;
	wire       line_fault = ev_noise | ev_frame | ev_overrun;
	wire       head_addr  = head[`UCR_ADDR_FLAG_BIT];

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pend_valid_reg <= 1'b0;
			pend_addr_reg  <= 8'h0_0;
			cmd_valid_reg  <= 1'b0;
			cmd_addr_reg   <= 8'h0_0;
			cmd_param_reg  <= 7'h0_0;
			ev_syntax      <= 1'b0;
			mmo_mode_reg   <= `UCR_MMO_RESET;
		end else if (ce) begin
			cmd_valid_reg <= 1'b0;
			ev_syntax     <= 1'b0;
			if (pop && head_addr) begin
				// Latest address replaces any earlier one silently
				pend_valid_reg <= 1'b1;
				pend_addr_reg  <= head;
			end else if (pop) begin
				// Parameter byte ends the pair either way
				pend_valid_reg <= 1'b0;
				if (!pend_valid_reg)
					ev_syntax <= 1'b1;
				else if (!addr_known(pend_addr_reg))
					ev_syntax <= 1'b1;
				else if (!value_legal(pend_addr_reg, head[6:0]))
					ev_syntax <= 1'b1;
				else begin
					cmd_valid_reg <= 1'b1;
					cmd_addr_reg  <= pend_addr_reg;
					cmd_param_reg <= head[6:0];
					if (pend_addr_reg == `UCR_ADDR_MMO_MODE)
						mmo_mode_reg <= head[1:0];
				end
			end
			if (line_fault)
				pend_valid_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sticky error flags; a new event beats a clear in the same cycle
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			err_noise_reg   <= 1'b0;
			err_frame_reg   <= 1'b0;
			err_overrun_reg <= 1'b0;
			err_syntax_reg  <= 1'b0;
		end else if (ce) begin
			err_noise_reg   <= ev_noise   | (err_noise_reg   & ~err_clear);
			err_frame_reg   <= ev_frame   | (err_frame_reg   & ~err_clear);
			err_overrun_reg <= ev_overrun | (err_overrun_reg & ~err_clear);
			err_syntax_reg  <= ev_syntax  | (err_syntax_reg  & ~err_clear);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit path on the output pin
	reg  [1:0]  tx_state_reg;
	reg  [11:0] tx_cnt_reg;
	reg  [3:0]  tx_bit_reg;
	reg  [9:0]  tx_shift_reg;
	wire        serial_mode = (mmo_mode_reg == `UCR_MMO_SERIAL);

	// Host replies (status, settings) only flow in serial function
	assign tx_ready = serial_mode & tx_state_reg[0];

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_state_reg <= TX_IDLE;
			tx_cnt_reg   <= 12'h0_000;
			tx_bit_reg   <= 4'h0;
			tx_shift_reg <= 10'h3_FF;
		end else if (ce) begin
			case (tx_state_reg)
			TX_IDLE: begin
				tx_shift_reg <= 10'h3_FF;
				if (tx_valid && serial_mode) begin
					// Stop, data, start: shifted out LSB first
					tx_shift_reg <= {1'b1, tx_data, 1'b0};
					tx_cnt_reg   <= BIT_CYC - 12'h0_001;
					tx_bit_reg   <= 4'h0;
					tx_state_reg <= TX_SHIFT;
				end
			end
			TX_SHIFT: begin
				if (tx_cnt_reg != 12'h0_000)
					tx_cnt_reg <= tx_cnt_reg - 12'h0_001;
				else begin
					tx_cnt_reg   <= BIT_CYC - 12'h0_001;
					tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
					tx_bit_reg   <= tx_bit_reg + 4'h1;
					if (tx_bit_reg == `UCR_FRAME_BITS - 1)
						tx_state_reg <= TX_IDLE;
				end
			end
			default: tx_state_reg <= TX_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin function select, registered so the pin never glitches
	always @(posedge clk or posedge rst) begin
		if (rst)
			multimode_output_pin <= 1'b0;
		else if (ce) begin
			case (mmo_mode_reg)
			`UCR_MMO_LEVEL:  multimode_output_pin <= detect_level;
			`UCR_MMO_PWM:    multimode_output_pin <= pwm_level;
			`UCR_MMO_SERIAL: multimode_output_pin <= tx_shift_reg[0];
			default:         multimode_output_pin <= detect_level;
			endcase
		end
	end

endmodule

// ==== ucr_receiver_asserts.sv ====
`timescale 1ns/1ps
module ucr_receiver_asserts (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       detect_level,
	input wire logic       tx_valid,
	input wire logic       tx_ready,
	input wire logic       err_clear,
	input wire logic       multimode_output_pin,
	input wire logic [1:0] mmo_mode_reg,
	input wire logic       cmd_valid_reg,
	input wire logic [7:0] cmd_addr_reg,
	input wire logic       err_noise_reg,
	input wire logic       err_frame_reg,
	input wire logic       err_overrun_reg,
	input wire logic       err_syntax_reg,
	input wire logic [3:0] fifo_level
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	wire [3:0] errs = {err_noise_reg, err_frame_reg, err_overrun_reg, err_syntax_reg};
	////////////////////////////////
	sequence tx_take;
		tx_valid && tx_ready;
	endsequence
	sequence tx_start_bit;
		##2 !multimode_output_pin ##1 !tx_ready;
	endsequence
	////////////////////////////////
	AST_TX_START: assert property (tx_take |-> tx_start_bit)
		else $error("start bit missing");
	AST_TX_OFF: assert property (mmo_mode_reg != 2'h2 |-> !tx_ready)
		else $error("ready outside serial");
	AST_TX_IDLE: assert property (
		(tx_ready && $past(mmo_mode_reg, 2) == 2'h2) |-> multimode_output_pin)
		else $error("serial pin not idle high");
	AST_LEVEL: assert property (
		(mmo_mode_reg == 2'h0 && $past(mmo_mode_reg) == 2'h0) |-> multimode_output_pin == $past(detect_level))
		else $error("pin not following level");
	AST_MODE_LEGAL: assert property (mmo_mode_reg != 2'h3)
		else $error("bad pin function");
	AST_MODE_CMD: assert property ($changed(mmo_mode_reg) |-> cmd_valid_reg || $past(cmd_valid_reg))
		else $error("function changed without command");
	AST_CMD_ADDR: assert property (cmd_valid_reg |-> cmd_addr_reg[7])
		else $error("command without address class");
	AST_FIFO_MAX: assert property (fifo_level <= 4'h8)
		else $error("buffer above eight");
	// Flags may only grow unless cleared
	AST_STICKY: assert property (!err_clear |=> (errs & $past(errs)) == $past(errs))
		else $error("error flag lost");
endmodule
bind ucr_receiver ucr_receiver_asserts ucr_receiver_asserts_i (
	.clk(clk), .rst(rst), .detect_level(detect_level), .tx_valid(tx_valid), .tx_ready(tx_ready),
	.err_clear(err_clear), .multimode_output_pin(multimode_output_pin), .mmo_mode_reg(mmo_mode_reg),
	.cmd_valid_reg(cmd_valid_reg), .cmd_addr_reg(cmd_addr_reg), .err_noise_reg(err_noise_reg),
	.err_frame_reg(err_frame_reg), .err_overrun_reg(err_overrun_reg), .err_syntax_reg(err_syntax_reg),
	.fifo_level(fifo_level));

// ==== ucr_host_model.sv ====
`timescale 1ns/1ps
`include "ucr_defs.vh"
module ucr_host_model (
	input  wire logic clk,
	output logic      line
);
	integer i;
	initial line = 1'b1; // Idle high
	task automatic bit_out(input logic v);
		begin
			@(posedge clk) line <= v;
			repeat (`UCR_BIT_CYC - 1) @(posedge clk);
		end
	endtask
	// Bit 7 of b picks address or parameter class
	task automatic send(input logic [7:0] b, input logic stop);
		begin
			bit_out(1'b0);
			for (i = 0; i < 8; i = i + 1)
				bit_out(b[i]);
			bit_out(stop); // Low only to provoke a framing fault
			@(posedge clk) line <= 1'b1;
		end
	endtask
	// Short low pulse: start edge seen, centre reads high
	task automatic glitch;
		begin
			@(posedge clk) line <= 1'b0;
			repeat (`UCR_HALF_CYC / 2) @(posedge clk);
			line <= 1'b1;
			// Receiver is back in idle half a bit after the edge; one bit of quiet is enough
			repeat (`UCR_BIT_CYC) @(posedge clk);
		end
	endtask
endmodule

// ==== uart_command_receiver_bench.sv ====
`timescale 1ns/1ps
`include "ucr_defs.vh"
module uart_command_receiver_bench;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic       detect_level = 1'b0;
	logic       tx_valid = 1'b0;
	logic [7:0] tx_data = 8'h0_0;
	logic       err_clear = 1'b0;
	wire        uart_rx, multimode_output_pin, tx_ready, cmd_valid_reg;
	wire        err_noise_reg, err_frame_reg, err_overrun_reg, err_syntax_reg;
	wire  [1:0] mmo_mode_reg;
	wire  [7:0] cmd_addr_reg;
	wire  [6:0] cmd_param_reg;
	wire  [3:0] fifo_level;
	integer     miscompares = 0;
	integer     cmp_count = 0;
	integer     cmd_seen = 0;
	ucr_host_model ucr_host_model_i (.clk(clk), .line(uart_rx));
	ucr_receiver ucr_receiver_i (
		.clk(clk), .rst(rst), .ce(1'b1), .uart_rx(uart_rx), .detect_level(detect_level),
		.pwm_level(1'b0), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
		.err_clear(err_clear), .multimode_output_pin(multimode_output_pin), .mmo_mode_reg(mmo_mode_reg),
		.cmd_valid_reg(cmd_valid_reg), .cmd_addr_reg(cmd_addr_reg), .cmd_param_reg(cmd_param_reg),
		.err_noise_reg(err_noise_reg), .err_frame_reg(err_frame_reg), .err_overrun_reg(err_overrun_reg),
		.err_syntax_reg(err_syntax_reg), .fifo_level(fifo_level));
	initial forever #2 clk = ~clk;
	always @(posedge clk) if (cmd_valid_reg === 1'b1) cmd_seen <= cmd_seen + 1;
	////////////////////////////////
	task automatic chk(input logic ok, input string msg);
		begin
			cmp_count = cmp_count + 1;
			if (ok !== 1'b1) begin
				miscompares = miscompares + 1;
				$display("mismatch at %0t: %s", $time, msg);
			end
		end
	endtask
	task automatic end_sim;
		begin
			$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
			if (miscompares == 0 && cmp_count > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	task automatic clear_flags;
		begin
			@(posedge clk) err_clear <= 1'b1;
			@(posedge clk) err_clear <= 1'b0;
			@(posedge clk) #1;
			chk({err_noise_reg, err_frame_reg, err_overrun_reg, err_syntax_reg} === 4'h0, "flags not cleared");
		end
	endtask
	////////////////////////////////
	task automatic t_level;
		begin
			@(posedge clk) detect_level <= 1'b1;
			repeat (3) @(posedge clk);
			#1 chk(multimode_output_pin === 1'b1 && mmo_mode_reg === 2'h0, "level function");
			$display("level test done");
		end
	endtask
	task automatic t_cmd;
		begin
			ucr_host_model_i.send(8'h8_0, 1'b1);
			ucr_host_model_i.send(8'h0_2, 1'b1);
			repeat (4) @(posedge clk);
			chk(cmd_seen == 1 && cmd_addr_reg === 8'h8_0 && cmd_param_reg === 7'h0_2, "command");
			chk(mmo_mode_reg === 2'h2 && tx_ready === 1'b1, "serial function");
			$display("command test done");
		end
	endtask
	// Runs while receive traffic flows: link is full duplex
	task automatic t_tx;
		logic [9:0] exp;
		integer     k;
		begin
			exp = {1'b1, 8'hA_5, 1'b0};
			@(posedge clk) tx_valid <= 1'b1;
			tx_data <= 8'hA_5;
			@(posedge clk);
			while (tx_ready !== 1'b1) @(posedge clk);
			tx_valid <= 1'b0;
			repeat (`UCR_HALF_CYC + 2) @(posedge clk);
			for (k = 0; k < 10; k = k + 1) begin
				#1 chk(multimode_output_pin === exp[k], "serial bit");
				repeat (`UCR_BIT_CYC) @(posedge clk);
			end
			$display("transmit test done");
		end
	endtask
	task automatic t_noise;
		begin
			clear_flags;
			ucr_host_model_i.send(8'h8_0, 1'b1);
			ucr_host_model_i.glitch;
			ucr_host_model_i.send(8'h0_1, 1'b1);
			repeat (4) @(posedge clk);
			chk(err_noise_reg === 1'b1 && err_frame_reg === 1'b0, "noise flag");
			chk(err_syntax_reg === 1'b1 && cmd_seen == 1, "orphan parameter");
			chk(mmo_mode_reg === 2'h2, "function kept");
			$display("noise test done");
		end
	endtask
	task automatic t_frame;
		begin
			clear_flags;
			ucr_host_model_i.send(8'h8_1, 1'b0);
			repeat (4) @(posedge clk);
			chk(err_frame_reg === 1'b1 && fifo_level === 4'h0, "framing fault");
			chk(err_noise_reg === 1'b0 && err_overrun_reg === 1'b0, "stray fault flag");
			$display("framing test done");
		end
	endtask
	////////////////////////////////
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_level;
		t_cmd;
		fork
			t_tx;
			t_noise;
		join
		t_frame;
		end_sim;
	end
	initial begin
		// Five frames of about 21700 cycles each plus short gaps
		repeat (120000) @(posedge clk);
		miscompares = miscompares + 1;
		end_sim;
	end
endmodule
